// ### wled_pkg.sv
// Package with register map, field layout, reset values and timing counts of the backlight block.
package wled_pkg;

  localparam logic [11:0] OFF_CTRL_ONE  = 12'h000;
  localparam logic [11:0] OFF_DUTY_CTRL = 12'h004;
  localparam logic [11:0] OFF_STATUS    = 12'h008;

  localparam int BIT_SINK_ENABLE = 0;
  localparam int BIT_CUR_SELECT  = 1;
  localparam int FREQ_LSB        = 4;
  localparam int FREQ_W          = 2;
  localparam int DUTY_W          = 7;
  localparam int POS_W           = 7;
  localparam int STAT_PWM_BIT    = 0;
  localparam int STAT_SINK_BIT   = 1;
  localparam int STAT_POS_LSB    = 8;

  localparam logic [1:0] FREQ_100HZ  = 2'h0;
  localparam logic [1:0] FREQ_200HZ  = 2'h1;
  localparam logic [1:0] FREQ_500HZ  = 2'h2;
  localparam logic [1:0] FREQ_1000HZ = 2'h3;

  localparam logic [1:0] FREQ_RESET  = FREQ_200HZ;
  localparam logic [6:0] DUTY_MIN    = 7'h01;
  localparam logic [6:0] DUTY_MAX    = 7'h64;
  localparam logic [6:0] DUTY_RESET  = DUTY_MIN;
  localparam logic [6:0] STEPS       = 7'h64;

  localparam int CLK_HZ = 40000000;
  localparam int HZ_100  = 100;
  localparam int HZ_200  = 200;
  localparam int HZ_500  = 500;
  localparam int HZ_1000 = 1000;
  // Cycles of one 1% step at each frequency: clock / (frequency * 100).
  localparam int STEP_100  = CLK_HZ / (HZ_100 * 100);
  localparam int STEP_200  = CLK_HZ / (HZ_200 * 100);
  localparam int STEP_500  = CLK_HZ / (HZ_500 * 100);
  localparam int STEP_1000 = CLK_HZ / (HZ_1000 * 100);

  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

endpackage

// ### wled_step_timer.sv
// Prescaler that pulses once per 1% step of the dimming period.
`timescale 1ns/1ps
module wled_step_timer #(
  parameter int W = 16
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_b_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] step_len_in,
  output logic              tick_out
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_q;
  logic         tick_d;

  always_comb begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + {{(W-1){1'b0}}, 1'b1};
    if (cnt_q >= step_len_in - {{(W-1){1'b0}}, 1'b1}) begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (ce_in) begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out = tick_q;
endmodule

// ### wled_pwm_ctrl.sv
// Top of the backlight dimming control: APB registers, PWM and sink gating.
//
// Behaviour
// - One select bit picks one current setting.
// - Both sinks share setting and dimming signal.
// - PWM resets 200 Hz; 100/500/1000 selectable.
// - Duty 1% to 100% in 1% steps, reset 1%.
// - Sink enable turns on sinks and boost.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
module wled_pwm_ctrl (
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             led_sink_a_out,
  output logic             led_sink_b_out,
  output logic             current_setting_select_out,
  output logic             boost_enable_out,
  output logic             pwm_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic        sink_enable_q;
  logic        sink_enable_d;
  logic        cur_sel_q;
  logic        cur_sel_d;
  logic [1:0]  freq_q;
  logic [1:0]  freq_d;
  logic [6:0]  duty_q;
  logic [6:0]  duty_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        ready_q;
  logic        ready_d;
  logic        err_q;
  logic        err_d;
  logic [6:0]  pos_q;
  logic [6:0]  pos_d;
  logic        pwm_q;
  logic        pwm_d;
  logic [1:0]  sink_q;
  logic [1:0]  sink_d;
  logic [15:0] step_sel;
  logic [15:0] step_len_q;
  logic [15:0] step_len_d;
  logic        tick;
  logic        wr_acc;
  logic        rd_acc;
  logic        hit;

  assign wr_acc = psel_in && penable_in && !ready_q && pwrite_in;
  assign rd_acc = psel_in && penable_in && !ready_q && !pwrite_in;
  assign hit    = (paddr_in == wled_pkg::OFF_CTRL_ONE) ||
                  (paddr_in == wled_pkg::OFF_DUTY_CTRL) ||
                  (paddr_in == wled_pkg::OFF_STATUS);

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, ready pulses for one cycle per access.

  always_comb begin
    sink_enable_d = sink_enable_q;
    cur_sel_d     = cur_sel_q;
    freq_d        = freq_q;
    duty_d        = duty_q;
    rdata_d       = rdata_q;
    ready_d       = 1'b0;
    err_d         = 1'b0;
    if (psel_in && penable_in && !ready_q) begin
      ready_d = 1'b1;
      err_d   = !hit;
    end
    if (wr_acc && pstrb_in[0]) begin
      if (paddr_in == wled_pkg::OFF_CTRL_ONE) begin
        sink_enable_d = pwdata_in[wled_pkg::BIT_SINK_ENABLE];
        cur_sel_d     = pwdata_in[wled_pkg::BIT_CUR_SELECT];
        freq_d        = pwdata_in[wled_pkg::FREQ_LSB +: wled_pkg::FREQ_W];
      end else if (paddr_in == wled_pkg::OFF_DUTY_CTRL) begin
        // Out-of-range values are clamped so the duty never leaves 1% to 100%.
        if (pwdata_in[wled_pkg::DUTY_W-1:0] < wled_pkg::DUTY_MIN) begin
          duty_d = wled_pkg::DUTY_MIN;
        end else if (pwdata_in[wled_pkg::DUTY_W-1:0] > wled_pkg::DUTY_MAX) begin
          duty_d = wled_pkg::DUTY_MAX;
        end else begin
          duty_d = pwdata_in[wled_pkg::DUTY_W-1:0];
        end
      end
    end
    if (rd_acc) begin
      rdata_d = wled_pkg::RD_ZERO;
      case (paddr_in)
        wled_pkg::OFF_CTRL_ONE: begin
          rdata_d[wled_pkg::BIT_SINK_ENABLE] = sink_enable_q;
          rdata_d[wled_pkg::BIT_CUR_SELECT]  = cur_sel_q;
          rdata_d[wled_pkg::FREQ_LSB +: wled_pkg::FREQ_W] = freq_q;
        end
        wled_pkg::OFF_DUTY_CTRL: begin
          rdata_d[wled_pkg::DUTY_W-1:0] = duty_q;
        end
        wled_pkg::OFF_STATUS: begin
          rdata_d[wled_pkg::STAT_PWM_BIT]                    = pwm_q;
          rdata_d[wled_pkg::STAT_SINK_BIT]                   = sink_q[0];
          rdata_d[wled_pkg::STAT_POS_LSB +: wled_pkg::POS_W] = pos_q;
        end
        default: begin
          rdata_d = wled_pkg::RD_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      sink_enable_q <= 1'b0;
      cur_sel_q     <= 1'b0;
      freq_q        <= wled_pkg::FREQ_RESET;
      duty_q        <= wled_pkg::DUTY_RESET;
      rdata_q       <= wled_pkg::RD_ZERO;
      ready_q       <= 1'b0;
      err_q         <= 1'b0;
    end else if (ce_in) begin
      sink_enable_q <= sink_enable_d;
      cur_sel_q     <= cur_sel_d;
      freq_q        <= freq_d;
      duty_q        <= duty_d;
      rdata_q       <= rdata_d;
      ready_q       <= ready_d;
      err_q         <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Dimming PWM: period of one hundred 1% steps.

  always_comb begin
    case (freq_q)
      wled_pkg::FREQ_100HZ:  step_sel = 16'(wled_pkg::STEP_100);
      wled_pkg::FREQ_200HZ:  step_sel = 16'(wled_pkg::STEP_200);
      wled_pkg::FREQ_500HZ:  step_sel = 16'(wled_pkg::STEP_500);
      wled_pkg::FREQ_1000HZ: step_sel = 16'(wled_pkg::STEP_1000);
      default:               step_sel = 16'(wled_pkg::STEP_200);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Step length, loaded only at a step boundary.

  // A new frequency waits for the running step to end, so no step is ever cut short.
  always_comb begin
    step_len_d = step_len_q;
    if (tick) begin
      step_len_d = step_sel;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      step_len_q <= 16'(wled_pkg::STEP_200);
    end else if (ce_in) begin
      step_len_q <= step_len_d;
    end
  end

  wled_step_timer #(
    .W(16)
  ) u_step (
    .core_clk_in (core_clk_in),
    .rst_b_in    (rst_b_in),
    .ce_in       (ce_in),
    .step_len_in (step_len_q),
    .tick_out    (tick)
  );

  always_comb begin
    pos_d = pos_q;
    if (tick) begin
      pos_d = (pos_q == wled_pkg::STEPS - 7'h01) ? 7'h00 : pos_q + 7'h01;
    end
    // High for the first duty steps of each period; duty 100 keeps it high throughout.
    pwm_d  = (pos_d < duty_q);
    // Disabled sinks stay dark whatever the PWM does.
    sink_d = {2{sink_enable_q && pwm_d}};
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      pos_q  <= 7'h00;
      pwm_q  <= 1'b0;
      sink_q <= 2'b00;
    end else if (ce_in) begin
      pos_q  <= pos_d;
      pwm_q  <= pwm_d;
      sink_q <= sink_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign prdata_out  = rdata_q;
  assign pready_out  = ready_q;
  assign pslverr_out = err_q;
  // Each sink has its own flop fed by one shared term, so the two can never differ.
  assign led_sink_a_out             = sink_q[0];
  assign led_sink_b_out             = sink_q[1];
  assign current_setting_select_out = cur_sel_q;
  assign boost_enable_out           = sink_enable_q;
  assign pwm_out                    = pwm_q;

endmodule

// ### wled_pwm_ctrl_chk.sv
// Assertion checker for the backlight dimming control block.
`timescale 1ns/1ps
module wled_pwm_ctrl_chk (
  input wire logic        core_clk_in,
  input wire logic        rst_b_in,
  input wire logic        ce_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0]  pstrb_in,
  input wire logic        pready_out,
  input wire logic        led_sink_a_out,
  input wire logic        led_sink_b_out,
  input wire logic        current_setting_select_out,
  input wire logic        boost_enable_out,
  input wire logic        pwm_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic wr_ctrl;
  assign wr_ctrl = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0] &&
                   paddr_in == wled_pkg::OFF_CTRL_ONE;
  AST_SINK_PAIR: assert property (
    led_sink_a_out == led_sink_b_out) else $error("sinks differ");
  AST_SINK_EN: assert property (
    $past(ce_in) && !$past(boost_enable_out) |-> !led_sink_a_out)
    else $error("sink on while disabled");
  AST_SINK_PWM: assert property (
    !pwm_out && !$past(pwm_out) |-> !led_sink_b_out) else $error("sink on while pwm low");
  AST_SINK_ON: assert property (
    $past(ce_in) && $past(boost_enable_out) && pwm_out |-> led_sink_a_out)
    else $error("sink off while gated on");
  AST_READY: assert property (
    ce_in && psel_in && penable_in && !pready_out |=> pready_out) else $error("no ready");
  AST_PULSE: assert property (
    pready_out && ce_in |=> !pready_out) else $error("ready too long");
  AST_BOOST: assert property (
    wr_ctrl && pwdata_in[wled_pkg::BIT_SINK_ENABLE] |=> boost_enable_out)
    else $error("boost not enabled");
  AST_SEL: assert property (
    wr_ctrl && pwdata_in[wled_pkg::BIT_CUR_SELECT] |=> current_setting_select_out)
    else $error("select not set");
endmodule
bind wled_pwm_ctrl wled_pwm_ctrl_chk u_chk (
  .core_clk_in                (core_clk_in),
  .rst_b_in                   (rst_b_in),
  .ce_in                      (ce_in),
  .psel_in                    (psel_in),
  .penable_in                 (penable_in),
  .pwrite_in                  (pwrite_in),
  .paddr_in                   (paddr_in),
  .pwdata_in                  (pwdata_in),
  .pstrb_in                   (pstrb_in),
  .pready_out                 (pready_out),
  .led_sink_a_out             (led_sink_a_out),
  .led_sink_b_out             (led_sink_b_out),
  .current_setting_select_out (current_setting_select_out),
  .boost_enable_out           (boost_enable_out),
  .pwm_out                    (pwm_out)
);

// ### wled_pwm_ctrl_test.sv
// Self-checking testbench of the backlight dimming control block.
`timescale 1ns/1ps
module wled_pwm_ctrl_test;
  logic        core_clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        ce_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic [3:0]  pstrb_in = 4'hF;
  logic [31:0] prdata_out, rd;
  logic        pready_out, pslverr_out, err, led_sink_a_out, led_sink_b_out;
  logic        current_setting_select_out, boost_enable_out, pwm_out;
  int          mismatches = 0, n_tests = 0, cycles = 0, w;
  wled_pwm_ctrl DUT (
    .core_clk_in                (core_clk_in),
    .rst_b_in                   (rst_b_in),
    .ce_in                      (ce_in),
    .psel_in                    (psel_in),
    .penable_in                 (penable_in),
    .pwrite_in                  (pwrite_in),
    .paddr_in                   (paddr_in),
    .pwdata_in                  (pwdata_in),
    .pstrb_in                   (pstrb_in),
    .prdata_out                 (prdata_out),
    .pready_out                 (pready_out),
    .pslverr_out                (pslverr_out),
    .led_sink_a_out             (led_sink_a_out),
    .led_sink_b_out             (led_sink_b_out),
    .current_setting_select_out (current_setting_select_out),
    .boost_enable_out           (boost_enable_out),
    .pwm_out                    (pwm_out)
  );
  always #12.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // A spare edge first, so a release and the next request never share a time step.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge core_clk_in);
    psel_in    <= 1'b1;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= d;
    pstrb_in   <= s;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    do @(posedge core_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic pwm_width(input int exp, input logic en);
    while (pwm_out !== 1'b1) @(posedge core_clk_in);
    w = 0;
    while (pwm_out === 1'b1) begin
      @(posedge core_clk_in);
      w++;
      if (w == 5) check({led_sink_a_out, led_sink_b_out}, {en, en});
    end
    check(w >= exp - 2 && w <= exp + 2, 1);
  endtask
  task automatic scn_reset();
    pwm_width(2000, 1'b0);
    apb(1'b0, 12'h000, 0, 4'hF);
    check(rd, 32'h10);
    apb(1'b0, 12'h004, 0, 4'hF);
    check(rd, 32'h1);
    check({boost_enable_out, current_setting_select_out}, 0);
  endtask
  task automatic scn_regs();
    apb(1'b1, 12'h000, 32'h33, 4'hF);
    apb(1'b1, 12'h000, 32'h0, 4'hE);
    apb(1'b0, 12'h000, 0, 4'hF);
    check(rd, 32'h33);
    check({boost_enable_out, current_setting_select_out}, 2'b11);
    apb(1'b1, 12'h004, 32'h0, 4'hF);
    apb(1'b0, 12'h004, 0, 4'hF);
    check(rd, 32'h1);
    apb(1'b1, 12'h004, 32'h7F, 4'hF);
    apb(1'b0, 12'h004, 0, 4'hF);
    check(rd, 32'h64);
    apb(1'b0, 12'h00C, 0, 4'hF);
    check(err, 1);
    check(rd, 0);
    apb(1'b0, 12'h008, 0, 4'hF);
    check(rd[1:0], 2'b11);
    check({led_sink_a_out, led_sink_b_out}, 2'b11);
  endtask
  task automatic scn_fast();
    apb(1'b1, 12'h004, 32'h1, 4'hF);
    while (pwm_out !== 1'b0) @(posedge core_clk_in);
    pwm_width(400, 1'b1);
    apb(1'b1, 12'h000, 32'h30, 4'hF);
    apb(1'b0, 12'h000, 0, 4'hF);
    check({boost_enable_out, current_setting_select_out, led_sink_a_out}, 0);
  endtask
  // Step length from the status position, polled every four cycles; the second gap is whole.
  task automatic scn_freq(input logic [1:0] f, input int exp);
    logic [6:0] p;
    int         n;
    apb(1'b1, 12'h000, {26'h0, f, 4'h0}, 4'hF);
    apb(1'b0, 12'h008, 0, 4'hF);
    n = 0;
    repeat (2) begin
      p = rd[14:8];
      n = 0;
      while (rd[14:8] == p && n < 3000) begin
        apb(1'b0, 12'h008, 0, 4'hF);
        n++;
      end
    end
    check(n * 4 >= exp - 8 && n * 4 <= exp + 8, 1);
  endtask
  // With the clock enable low the step position must not move.
  task automatic scn_hold();
    logic [6:0] p;
    apb(1'b0, 12'h008, 0, 4'hF);
    p = rd[14:8];
    ce_in <= 1'b0;
    repeat (2000) @(posedge core_clk_in);
    ce_in <= 1'b1;
    apb(1'b0, 12'h008, 0, 4'hF);
    check(7'(rd[14:8] - p) <= 7'h01, 1);
  endtask
  initial begin
    repeat (3) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    scn_reset();
    scn_regs();
    scn_fast();
    scn_freq(wled_pkg::FREQ_100HZ, wled_pkg::STEP_100);
    scn_freq(wled_pkg::FREQ_500HZ, wled_pkg::STEP_500);
    scn_hold();
    conclude();
  end
endmodule
